// File: verilog/crt_cfg.svh
// Purpose: Offsets, field positions, reset values and codes of the
//          clock reference and receive termination register bank.
// Assumes: 32-bit AXI4-Lite data, one aligned word per register.
// Notes:   Included by its bare name; definitions only.
`ifndef CRT_CFG_SVH
`define CRT_CFG_SVH

`define CRT_NUM_CH 14
`define CRT_ADDR_W 8

// Register byte addresses
`define CRT_ADDR_GCTRL 8'h00
`define CRT_ADDR_GSTAT 8'h04
`define CRT_SEG_CHCFG 2'h1
`define CRT_SEG_CHLOSS 2'h2

// Global control fields
`define CRT_GC_REFSEL_LSB 0
`define CRT_GC_GATE_DIS_BIT 4
`define CRT_GC_PIN_OVR_BIT 5
`define CRT_GC_TERSEL_LSB 6
`define CRT_GC_FAMILY_BIT 8
`define CRT_GC_W 9
`define CRT_GC_RESET 9'h000

// Global status fields
`define CRT_GS_T1_ON_BIT 0
`define CRT_GS_E1_ON_BIT 1
`define CRT_GS_8K_ON_BIT 2

// Channel configuration fields
`define CRT_CC_TERM_EN_BIT 0
`define CRT_CC_EXTRES_LSB 1
`define CRT_CC_EQ_LSB 3
`define CRT_CC_EQ_E1_BIT 6
`define CRT_CC_W 7
`define CRT_CC_RESET 7'h00

`define CRT_LOSS_W 6

// AXI responses
`define CRT_RESP_OKAY 2'h0
`define CRT_RESP_SLVERR 2'h2

// Reference frequencies in kHz
`define CRT_FREQ_W 15
`define CRT_KHZ_2048 15'h0800
`define CRT_KHZ_1544 15'h0608
`define CRT_KHZ_8 15'h0008
`define CRT_KHZ_16 15'h0010
`define CRT_KHZ_56 15'h0038
`define CRT_KHZ_64 15'h0040
`define CRT_KHZ_128 15'h0080
`define CRT_KHZ_256 15'h0100
`define CRT_KHZ_4096 15'h1000
`define CRT_KHZ_3088 15'h0c10
`define CRT_KHZ_8192 15'h2000
`define CRT_KHZ_6176 15'h1820
`define CRT_KHZ_16384 15'h4000
`define CRT_KHZ_12352 15'h3040

`endif

// File: verilog/crt_pkg.sv
// Purpose: Shared types of the clock reference and termination bank.
// Assumes: Field widths as in crt_cfg.svh.
// Notes:   Types only; numbers live in the header.
`include "crt_cfg.svh"
package crt_pkg;
    typedef logic [3:0] crt_refsel_t;
    typedef logic [1:0] crt_tersel_t;
    typedef logic [1:0] crt_extres_t;
    typedef logic [`CRT_LOSS_W-1:0] crt_loss_t;
    typedef logic [`CRT_FREQ_W-1:0] crt_freq_t;
    typedef logic [`CRT_CC_W-1:0] crt_chcfg_t;
endpackage : crt_pkg

// File: verilog/crt_chan_if.sv
// Purpose: Link between the bank top and one channel's settings.
// Assumes: One write at a time from the top.
// Notes:   ctl is the top's view, chan the channel's.
`include "crt_cfg.svh"
interface crt_chan_if;
    logic wr;
    logic [`CRT_CC_W-1:0] wdata;
    logic pin_ovr;
    logic pin_term;
    logic [`CRT_CC_W-1:0] cfg;
    logic term_on;
    logic is_e1;
    modport ctl (output wr, output wdata, output pin_ovr,
        output pin_term, input cfg, input term_on, input is_e1);
    modport chan (input wr, input wdata, input pin_ovr,
        input pin_term, output cfg, output term_on, output is_e1);
endinterface : crt_chan_if

// File: verilog/crt_chan.sv
// Purpose: One channel's configuration register and termination control.
// Assumes: pin_term already synchronised to CLOCK.
// Notes:   Each channel holds its own configuration copy; only wdata, pin_ovr and pin_term are shared.
`include "crt_cfg.svh"
module crt_chan
    import crt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    crt_chan_if.chan bus
);
    crt_chcfg_t cfg_ff;
    crt_chcfg_t nxt_cfg;
    logic term_on_ff;
    logic is_e1_ff;
    logic nxt_term_on;

    // Only this channel's strobe updates it
    assign nxt_cfg = bus.wr ? bus.wdata : cfg_ff;
    // Pin wins while override is set, else channel bit
    assign nxt_term_on = bus.pin_ovr ? bus.pin_term :
        cfg_ff[`CRT_CC_TERM_EN_BIT];

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_ff <= `CRT_CC_RESET;
            term_on_ff <= 1'b0;
            is_e1_ff <= 1'b0;
        end else begin
            cfg_ff <= nxt_cfg;
            term_on_ff <= nxt_term_on;
            is_e1_ff <= cfg_ff[`CRT_CC_EQ_E1_BIT];
        end
    end

    assign bus.cfg = cfg_ff;
    assign bus.term_on = term_on_ff;
    assign bus.is_e1 = is_e1_ff;
endmodule : crt_chan

// File: verilog/crt_top.sv
// Purpose: AXI4-Lite register bank for synthesizer reference selection,
//          single-rate clock gating and per-channel receive termination.
// Assumes: CLOCK 20 MHz, RST synchronous active high; pins asynchronous.
// Notes:   Analog blocks consume the outputs; this is control only.
`include "crt_cfg.svh"
module crt_top
    import crt_pkg::*;
#(
    parameter int NUM_CH = `CRT_NUM_CH
)
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [`CRT_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [`CRT_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic RX_TERM_PIN,
    input wire logic [NUM_CH*`CRT_LOSS_W-1:0] CABLE_LOSS,
    output logic [3:0] REF_CLOCK_SELECT,
    output logic [`CRT_FREQ_W-1:0] REF_FREQ_KHZ,
    output logic [NUM_CH-1:0] T1_REF_EN,
    output logic [NUM_CH-1:0] E1_REF_EN,
    output logic REF_8K_EN,
    output logic [1:0] TERMINATION_IMPEDANCE_SELECT,
    output logic [NUM_CH-1:0] RX_TERM_ON,
    output logic [NUM_CH-1:0] CHAN_IS_E1,
    output logic [NUM_CH*2-1:0] EXTERNAL_RESISTOR_SELECT
);
    localparam int LW = `CRT_LOSS_W;

    function automatic crt_freq_t ref_khz(input crt_refsel_t sel);
        crt_freq_t f;
        f = `CRT_KHZ_2048;
        case (sel)
            4'h0, 4'he: f = `CRT_KHZ_2048;
            4'h1, 4'hf: f = `CRT_KHZ_1544;
            4'h2: f = `CRT_KHZ_8;
            4'h3: f = `CRT_KHZ_16;
            4'h4: f = `CRT_KHZ_56;
            4'h5: f = `CRT_KHZ_64;
            4'h6: f = `CRT_KHZ_128;
            4'h7: f = `CRT_KHZ_256;
            4'h8: f = `CRT_KHZ_4096;
            4'h9: f = `CRT_KHZ_3088;
            4'ha: f = `CRT_KHZ_8192;
            4'hb: f = `CRT_KHZ_6176;
            4'hc: f = `CRT_KHZ_16384;
            default: f = `CRT_KHZ_12352;
        endcase
        return f;
    endfunction : ref_khz

    // Pin synchronisers
    logic pin_meta_ff;
    logic pin_sync_ff;
    logic [NUM_CH*LW-1:0] loss_meta_ff;
    logic [NUM_CH*LW-1:0] loss_sync_ff;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
            loss_meta_ff <= '0;
            loss_sync_ff <= '0;
        end else begin
            pin_meta_ff <= RX_TERM_PIN;
            pin_sync_ff <= pin_meta_ff;
            loss_meta_ff <= CABLE_LOSS;
            loss_sync_ff <= loss_meta_ff;
        end
    end

    // A channel's loss word is taken only when two samples in a row
    // agree, so a word caught mid-change never reaches the read path
    logic [NUM_CH*LW-1:0] loss_last_ff;
    logic [NUM_CH*LW-1:0] loss_ff;
    logic [NUM_CH-1:0] loss_steady;

    genvar gl;
    generate
        for (gl = 0; gl < NUM_CH; gl++) begin : g_loss
            assign loss_steady[gl] =
                loss_sync_ff[gl*LW +: LW] == loss_last_ff[gl*LW +: LW];
        end
    endgenerate

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            loss_last_ff <= '0;
            loss_ff <= '0;
        end else begin
            loss_last_ff <= loss_sync_ff;
            for (int n = 0; n < NUM_CH; n++) begin
                if (loss_steady[n]) begin
                    loss_ff[n*LW +: LW] <= loss_sync_ff[n*LW +: LW];
                end
            end
        end
    end

    // Write channel: address and data taken in either order
    logic aw_held_ff;
    logic w_held_ff;
    logic [`CRT_ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic awready_ff;
    logic wready_ff;
    logic nxt_aw_held;
    logic nxt_w_held;
    logic nxt_bvalid;

    wire aw_take = S_AXI_AWVALID && awready_ff;
    wire w_take = S_AXI_WVALID && wready_ff;
    wire wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;

    // Readies are registered inverses of what the holds and bvalid will be next
    assign nxt_aw_held = !wr_fire && (aw_take || aw_held_ff);
    assign nxt_w_held = !wr_fire && (w_take || w_held_ff);
    assign nxt_bvalid = wr_fire || (bvalid_ff && !S_AXI_BREADY);

    wire [1:0] wr_seg = awaddr_ff[7:6];
    wire [3:0] wr_idx = awaddr_ff[5:2];
    wire wr_aligned = awaddr_ff[1:0] == 2'h0;
    wire wr_idx_ok = 32'(wr_idx) < NUM_CH;
    wire wr_gctrl = wr_aligned && awaddr_ff == `CRT_ADDR_GCTRL;
    wire wr_gstat = wr_aligned && awaddr_ff == `CRT_ADDR_GSTAT;
    wire wr_chcfg = wr_aligned && wr_seg == `CRT_SEG_CHCFG && wr_idx_ok;
    wire wr_chloss = wr_aligned && wr_seg == `CRT_SEG_CHLOSS && wr_idx_ok;
    wire wr_mapped = wr_gctrl || wr_gstat || wr_chcfg || wr_chloss;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `CRT_RESP_OKAY;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
        end else begin
            awready_ff <= !nxt_aw_held && !nxt_bvalid;
            wready_ff <= !nxt_w_held && !nxt_bvalid;
            if (aw_take) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= S_AXI_AWADDR;
            end
            if (w_take) begin
                w_held_ff <= 1'b1;
                wdata_ff <= S_AXI_WDATA;
                wstrb_ff <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_mapped ? `CRT_RESP_OKAY : `CRT_RESP_SLVERR;
            end else if (bvalid_ff && S_AXI_BREADY) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Global control register, byte lanes honoured
    logic [`CRT_GC_W-1:0] gctrl_ff;
    logic [`CRT_GC_W-1:0] nxt_gctrl;
    assign nxt_gctrl = {
        (wr_fire && wr_gctrl && wstrb_ff[1]) ? wdata_ff[8] : gctrl_ff[8],
        (wr_fire && wr_gctrl && wstrb_ff[0]) ? wdata_ff[7:0] : gctrl_ff[7:0]
    };

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            gctrl_ff <= `CRT_GC_RESET;
        end else begin
            gctrl_ff <= nxt_gctrl;
        end
    end

    wire crt_refsel_t refsel = gctrl_ff[`CRT_GC_REFSEL_LSB +: 4];
    wire gate_on = !gctrl_ff[`CRT_GC_GATE_DIS_BIT];
    wire family_e1 = gctrl_ff[`CRT_GC_FAMILY_BIT];
    wire pin_ovr = gctrl_ff[`CRT_GC_PIN_OVR_BIT];
    wire crt_tersel_t tersel = gctrl_ff[`CRT_GC_TERSEL_LSB +: 2];

    // Gating of the two reference families and the 8 kHz output
    wire t1_on = !gate_on || !family_e1;
    wire e1_on = !gate_on || family_e1;
    wire k8_on = !gate_on || family_e1;

    // Channel instances
    logic [NUM_CH-1:0] ch_term_on;
    logic [NUM_CH-1:0] ch_is_e1;
    logic [NUM_CH*2-1:0] ch_extres;
    logic [31:0] ch_cfg_word [NUM_CH];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            crt_chan_if cif ();
            assign cif.wr = wr_fire && wr_chcfg && wstrb_ff[0] &&
                32'(wr_idx) == gi;
            assign cif.wdata = wdata_ff[`CRT_CC_W-1:0];
            assign cif.pin_ovr = pin_ovr;
            assign cif.pin_term = pin_sync_ff;
            assign ch_term_on[gi] = cif.term_on;
            assign ch_is_e1[gi] = cif.is_e1;
            assign ch_extres[gi*2 +: 2] =
                cif.cfg[`CRT_CC_EXTRES_LSB +: 2];
            assign ch_cfg_word[gi] = {{(32-`CRT_CC_W){1'b0}}, cif.cfg};
            crt_chan u_chan (
                .clk(CLOCK),
                .rst(RST),
                .bus(cif.chan)
            );
        end
    endgenerate

    // Read channel
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic nxt_rvalid;

    wire ar_take = S_AXI_ARVALID && arready_ff;
    assign nxt_rvalid = ar_take || (rvalid_ff && !S_AXI_RREADY);
    wire [1:0] rd_seg = S_AXI_ARADDR[7:6];
    wire [3:0] rd_idx = S_AXI_ARADDR[5:2];
    wire rd_aligned = S_AXI_ARADDR[1:0] == 2'h0;
    wire rd_idx_ok = 32'(rd_idx) < NUM_CH;
    wire rd_gctrl = rd_aligned && S_AXI_ARADDR == `CRT_ADDR_GCTRL;
    wire rd_gstat = rd_aligned && S_AXI_ARADDR == `CRT_ADDR_GSTAT;
    wire rd_chcfg = rd_aligned && rd_seg == `CRT_SEG_CHCFG && rd_idx_ok;
    wire rd_chloss = rd_aligned && rd_seg == `CRT_SEG_CHLOSS && rd_idx_ok;
    wire [3:0] rd_sel = rd_idx_ok ? rd_idx : 4'h0;
    wire crt_loss_t rd_loss = loss_ff[32'(rd_sel)*LW +: LW];
    wire [31:0] gstat_word = {29'h0, k8_on, e1_on, t1_on};
    wire [31:0] rd_word =
        rd_gctrl ? {{(32-`CRT_GC_W){1'b0}}, gctrl_ff} :
        rd_gstat ? gstat_word :
        rd_chcfg ? ch_cfg_word[rd_sel] :
        rd_chloss ? {{(32-LW){1'b0}}, rd_loss} : 32'h0;
    wire rd_mapped = rd_gctrl || rd_gstat || rd_chcfg || rd_chloss;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= `CRT_RESP_OKAY;
            arready_ff <= 1'b0;
        end else begin
            arready_ff <= !nxt_rvalid;
            if (ar_take) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_word;
                rresp_ff <= rd_mapped ? `CRT_RESP_OKAY : `CRT_RESP_SLVERR;
            end else if (rvalid_ff && S_AXI_RREADY) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            REF_CLOCK_SELECT <= '0;
            REF_FREQ_KHZ <= `CRT_KHZ_2048;
            T1_REF_EN <= '0;
            E1_REF_EN <= '0;
            REF_8K_EN <= 1'b0;
            TERMINATION_IMPEDANCE_SELECT <= '0;
            RX_TERM_ON <= '0;
            CHAN_IS_E1 <= '0;
            EXTERNAL_RESISTOR_SELECT <= '0;
        end else begin
            REF_CLOCK_SELECT <= refsel;
            REF_FREQ_KHZ <= ref_khz(refsel);
            T1_REF_EN <= {NUM_CH{t1_on}};
            E1_REF_EN <= {NUM_CH{e1_on}};
            REF_8K_EN <= k8_on;
            TERMINATION_IMPEDANCE_SELECT <= tersel;
            RX_TERM_ON <= ch_term_on;
            CHAN_IS_E1 <= ch_is_e1;
            EXTERNAL_RESISTOR_SELECT <= ch_extres;
        end
    end

    assign S_AXI_AWREADY = awready_ff;
    assign S_AXI_WREADY = wready_ff;
    assign S_AXI_BVALID = bvalid_ff;
    assign S_AXI_BRESP = bresp_ff;
    assign S_AXI_ARREADY = arready_ff;
    assign S_AXI_RVALID = rvalid_ff;
    assign S_AXI_RDATA = rdata_ff;
    assign S_AXI_RRESP = rresp_ff;
endmodule : crt_top

// File: testbench/crt_top_asserts.sv
// Purpose: Port-level checks of the reference and termination bank.
// Assumes: One clock; RST synchronous, active high.
// Notes:   Bound to crt_top from the bench top file.
`include "crt_cfg.svh"
module crt_top_asserts
    import crt_pkg::*;
#(
    parameter int NUM_CH = `CRT_NUM_CH
)
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic [3:0] REF_CLOCK_SELECT,
    input wire logic [`CRT_FREQ_W-1:0] REF_FREQ_KHZ,
    input wire logic [NUM_CH-1:0] T1_REF_EN,
    input wire logic [NUM_CH-1:0] E1_REF_EN,
    input wire logic REF_8K_EN,
    input wire logic [NUM_CH-1:0] RX_TERM_ON,
    input wire logic [NUM_CH*2-1:0] EXTERNAL_RESISTOR_SELECT
);
    localparam crt_freq_t FQ [16] = '{`CRT_KHZ_2048, `CRT_KHZ_1544,
        `CRT_KHZ_8, `CRT_KHZ_16, `CRT_KHZ_56, `CRT_KHZ_64, `CRT_KHZ_128,
        `CRT_KHZ_256, `CRT_KHZ_4096, `CRT_KHZ_3088, `CRT_KHZ_8192,
        `CRT_KHZ_6176, `CRT_KHZ_16384, `CRT_KHZ_12352, `CRT_KHZ_2048,
        `CRT_KHZ_1544};
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);
    sequence wr_both;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence bresp_soon;
        ##[2:3] S_AXI_BVALID;
    endsequence
    freq_decode_a: assert property (
        REF_FREQ_KHZ == FQ[REF_CLOCK_SELECT])
        else $error("reference frequency does not follow select");
    t1_gate_a: assert property (!$past(RST) && E1_REF_EN == '0 |->
        &T1_REF_EN && !REF_8K_EN) else $error("T1 gating wrong");
    e1_gate_a: assert property (!$past(RST) && T1_REF_EN == '0 |->
        &E1_REF_EN && REF_8K_EN) else $error("E1 gating wrong");
    rate_pair_a: assert property (!$past(RST) |->
        E1_REF_EN == {NUM_CH{REF_8K_EN}} && (T1_REF_EN == '0 || &T1_REF_EN))
        else $error("channel references not uniform");
    wr_answer_a: assert property (wr_both |-> bresp_soon)
        else $error("write response late");
    rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
        S_AXI_RVALID) else $error("read response late");
    wr_block_a: assert property (S_AXI_BVALID |->
        !S_AXI_AWREADY && !S_AXI_WREADY) else $error("write taken early");
    rd_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read taken early");
    resp_drop_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=>
        !S_AXI_BVALID) else $error("write response not released");
    reset_term_a: assert property ($fell(RST) |->
        RX_TERM_ON == '0 && EXTERNAL_RESISTOR_SELECT == '0)
        else $error("bad termination reset");
endmodule : crt_top_asserts

// File: testbench/crt_top_tb_top.sv
// Purpose: Self-checking bench for the reference and termination bank.
// Assumes: AXI4-Lite master driven by NBA on rising edges.
// Notes:   Reset checks first, then table rows, then hand-written cases.
`include "crt_cfg.svh"
module crt_top_tb_top
    import crt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] a; logic [31:0] d, x;
        logic [1:0] r;} crt_row_t;
    logic CLOCK, RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
    logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID;
    logic S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, RX_TERM_PIN, REF_8K_EN;
    logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, TERMINATION_IMPEDANCE_SELECT;
    logic [3:0] REF_CLOCK_SELECT;
    logic [13:0] T1_REF_EN, E1_REF_EN, RX_TERM_ON, CHAN_IS_E1;
    logic [27:0] EXTERNAL_RESISTOR_SELECT;
    logic [83:0] CABLE_LOSS;
    crt_freq_t REF_FREQ_KHZ;
    logic t1, e1;
    int fails, comparisons, i;
    crt_freq_t fq [16] = '{`CRT_KHZ_2048, `CRT_KHZ_1544, `CRT_KHZ_8,
        `CRT_KHZ_16, `CRT_KHZ_56, `CRT_KHZ_64, `CRT_KHZ_128, `CRT_KHZ_256,
        `CRT_KHZ_4096, `CRT_KHZ_3088, `CRT_KHZ_8192, `CRT_KHZ_6176,
        `CRT_KHZ_16384, `CRT_KHZ_12352, `CRT_KHZ_2048, `CRT_KHZ_1544};
    // Loss of channel n is 3n+1
    crt_row_t rows [9] = '{'{8'h00, 32'h1ff, 32'h1ff, 2'h0},
        '{8'h04, 32'h0, 32'h7, 2'h0}, '{8'h40, 32'h7f, 32'h7f, 2'h0},
        '{8'h74, 32'h35, 32'h35, 2'h0}, '{8'h80, 32'h3f, 32'h1, 2'h0},
        '{8'hb4, 32'h0, 32'h28, 2'h0}, '{8'hc0, 32'h5, 32'h0, 2'h2},
        '{8'h41, 32'h1, 32'h0, 2'h2}, '{8'h44, 32'hffffffff, 32'h7f, 2'h0}};
    crt_top i_crt_top (.CLOCK(CLOCK), .RST(RST),
        .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWPROT(3'h0),
        .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
        .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
        .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
        .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
        .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(S_AXI_ARVALID),
        .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
        .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
        .S_AXI_RREADY(S_AXI_RREADY), .RX_TERM_PIN(RX_TERM_PIN),
        .CABLE_LOSS(CABLE_LOSS), .REF_CLOCK_SELECT(REF_CLOCK_SELECT),
        .REF_FREQ_KHZ(REF_FREQ_KHZ), .T1_REF_EN(T1_REF_EN),
        .E1_REF_EN(E1_REF_EN), .REF_8K_EN(REF_8K_EN),
        .TERMINATION_IMPEDANCE_SELECT(TERMINATION_IMPEDANCE_SELECT),
        .RX_TERM_ON(RX_TERM_ON), .CHAN_IS_E1(CHAN_IS_E1),
        .EXTERNAL_RESISTOR_SELECT(EXTERNAL_RESISTOR_SELECT));
    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t word %h want %h", $time, g, e);
        end
    endtask : cmp_word
    task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t resp %h want %h", $time, g, e);
        end
    endtask : cmp_resp
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        @(posedge CLOCK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do begin
            @(posedge CLOCK);
            if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (S_AXI_BVALID !== 1'b1);
        cmp_resp(S_AXI_BRESP, er);
        S_AXI_BREADY <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        @(posedge CLOCK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            @(posedge CLOCK);
            if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (S_AXI_RVALID !== 1'b1);
        cmp_word(S_AXI_RDATA, ed);
        cmp_resp(S_AXI_RRESP, er);
        S_AXI_RREADY <= 1'b0;
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(negedge CLOCK);
    endtask : wt
    task automatic close_out;
        if (fails == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    initial begin
        CLOCK = 1'b0;
        forever #25 CLOCK = ~CLOCK;
    end
    initial begin
        repeat (5000) @(posedge CLOCK);
        fails++;
        close_out;
    end
    initial begin
        fails = 0;
        comparisons = 0;
        RST = 1'b1;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 3'h0;
        {S_AXI_ARVALID, S_AXI_RREADY, RX_TERM_PIN} = 3'h0;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
        for (i = 0; i < 14; i++) CABLE_LOSS[6*i+:6] = 6'(3*i+1);
        repeat (5) @(posedge CLOCK);
        RST <= 1'b0;
        wt(2);
        cmp_word(32'(T1_REF_EN), 32'h3fff);
        cmp_word(32'(E1_REF_EN), 32'h0);
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h40, 32'h0, 2'h0);
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].d, rows[k].r);
            rd(rows[k].a, rows[k].x, rows[k].r);
        end
        for (i = 0; i < 16; i++) begin
            wr(8'h00, 32'({i[1:0], 2'h0, i[3:0]}), 2'h0);
            wt(2);
            cmp_word(32'(REF_CLOCK_SELECT), 32'(i));
            cmp_word(32'(REF_FREQ_KHZ), 32'(fq[i]));
            cmp_word(32'(TERMINATION_IMPEDANCE_SELECT), 32'(i[1:0]));
        end
        for (i = 0; i < 4; i++) begin
            t1 = i[0] | !i[1];
            e1 = i[0] | i[1];
            wr(8'h00, 32'({i[1], 3'h0, i[0], 4'h0}), 2'h0);
            wt(2);
            cmp_word(32'(T1_REF_EN), 32'({14{t1}}));
            cmp_word(32'(E1_REF_EN), 32'({14{e1}}));
            cmp_word(32'(REF_8K_EN), 32'(e1));
            rd(8'h04, 32'({e1, e1, t1}), 2'h0);
        end
        wr(8'h4c, 32'h1, 2'h0);
        wr(8'h54, 32'h44, 2'h0);
        RX_TERM_PIN <= 1'b1;
        wt(6);
        cmp_word(32'(RX_TERM_ON), 32'h200b);
        cmp_word(32'(CHAN_IS_E1), 32'h23);
        cmp_word(32'(EXTERNAL_RESISTOR_SELECT), 32'h800080f);
        wr(8'h00, 32'h20, 2'h0);
        wt(6);
        cmp_word(32'(RX_TERM_ON), 32'h3fff);
        @(posedge CLOCK);
        RX_TERM_PIN <= 1'b0;
        wt(6);
        cmp_word(32'(RX_TERM_ON), 32'h0);
        @(posedge CLOCK);
        RST <= 1'b1;
        repeat (2) @(posedge CLOCK);
        RST <= 1'b0;
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h4c, 32'h0, 2'h0);
        close_out;
    end
endmodule : crt_top_tb_top
bind crt_top crt_top_asserts #(.NUM_CH(NUM_CH)) i_crt_top_asserts (
    .CLOCK(CLOCK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
    .REF_CLOCK_SELECT(REF_CLOCK_SELECT), .REF_FREQ_KHZ(REF_FREQ_KHZ),
    .T1_REF_EN(T1_REF_EN), .E1_REF_EN(E1_REF_EN), .REF_8K_EN(REF_8K_EN),
    .RX_TERM_ON(RX_TERM_ON),
    .EXTERNAL_RESISTOR_SELECT(EXTERNAL_RESISTOR_SELECT));
